// ---- src/dpl_core.sv ----
// Set-password and unlock command interpreter with lock state and attempt counter.
// Assumes the host writes the command and data registers synchronous to i_clk.
//
// Behaviour
// - Opcode F1h sets master or user password
// - User password locks only after next reset
// - Master identifier stores master password only
// - Set sector: id, level, password, revision
// - All 32 password bytes are significant
// - Revision recorded only for master identifier
// - Revision code reported as identify word 92
// - Level bit: zero high, one maximum
// - High level: user or master unlocks
// - Maximum level: only user password unlocks
// - Maximum level forgotten user: no unlock
// - Opcode F2h matching unlocks, passwords unchanged
// - Reset after unlock relocks the device
// - Unlock sector: identifier and password words
// - Master unlock: compare high, reject maximum
// - User unlock compares stored user password
// - Mismatch aborts, decrements counter reset five
// - Counter zero rejects protected commands
// - Frozen mode aborts both commands
`timescale 1ns/10ps

module dpl_core #(
    parameter int ATTEMPTS = dpl_pkg::ATTEMPTS_RESET
) (
    input  wire logic                 i_clk,
    input  wire logic                 i_rst,
    input  wire logic                 i_hard_rst,
    input  wire logic                 i_frozen,
    input  wire logic                 i_cmd_wr,
    input  wire logic [7:0]           i_cmd,
    input  wire logic                 i_data_wr,
    input  wire logic [15:0]          i_data,
    output      dpl_pkg::dpl_status_t o_status,
    output      dpl_pkg::dpl_error_t  o_error,
    output      logic                 o_cmd_done,
    output      logic                 o_locked,
    output      logic                 o_lock_enabled,
    output      logic                 o_level_max,
    output      logic [2:0]           o_attempts,
    output      logic [15:0]          o_ident_word92
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    generate
        if (ATTEMPTS < 1 || ATTEMPTS > 7) begin : g_bad_attempts
            $error("ATTEMPTS must be 1 to 7");
        end
    endgenerate

    localparam logic [2:0] ATTEMPTS_INIT = 3'(ATTEMPTS);
    localparam logic [7:0] LAST_WORD     = 8'(dpl_pkg::SECTOR_WORDS - 1);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    dpl_pkg::dpl_state_t state;
    logic [7:0]          cur_op;
    logic [7:0]          word_idx;
    logic [15:0]         ctrl_word;
    logic [15:0]         rev_word;
    logic [15:0]         pw_words [dpl_pkg::PW_WORDS];
    logic [255:0]        pw_rx;
    logic [255:0]        user_pw;
    logic [255:0]        master_pw;
    logic                abort_flag;
    logic                take_cmd;
    logic                early_abort;
    logic                sector_end;
    logic                is_master;
    logic                pw_match;
    logic                unlock_ok;
    logic                unlock_bad;
    logic                set_ok;
    logic                exec_abort;

    assign take_cmd    = (state == dpl_pkg::ST_IDLE) && i_cmd_wr &&
                         (i_cmd == dpl_pkg::OP_SET_PASSWORD || i_cmd == dpl_pkg::OP_UNLOCK);
    assign early_abort = take_cmd && (i_frozen || o_attempts == 3'h0);
    assign sector_end  = (state == dpl_pkg::ST_XFER) && i_data_wr && (word_idx == LAST_WORD);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // wait for full sector
    always_ff @(posedge i_clk) begin
        if (i_rst || i_hard_rst) begin
            state <= dpl_pkg::ST_IDLE;
        end else begin
            case (state)
                dpl_pkg::ST_IDLE: begin
                    if (take_cmd && !early_abort) begin
                        state <= dpl_pkg::ST_XFER;
                    end
                end
                dpl_pkg::ST_XFER: begin
                    if (sector_end) begin
                        state <= dpl_pkg::ST_EXEC;
                    end
                end
                dpl_pkg::ST_EXEC: begin
                    state <= dpl_pkg::ST_IDLE;
                end
                default: begin
                    state <= dpl_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cur_op <= 8'h00;
        end else if (take_cmd) begin
            cur_op <= i_cmd;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || i_hard_rst || state != dpl_pkg::ST_XFER) begin
            word_idx <= 8'h00;
        end else if (i_data_wr) begin
            word_idx <= word_idx + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Sector capture
    // ------------------------------------------------------------
    // control and revision words
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ctrl_word <= 16'h0000;
            rev_word  <= 16'h0000;
        end else if (state == dpl_pkg::ST_XFER && i_data_wr) begin
            if (word_idx == 8'h00) begin
                ctrl_word <= i_data;
            end
            if (word_idx == dpl_pkg::REV_WORD) begin
                rev_word <= i_data;
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < dpl_pkg::PW_WORDS; g++) begin : g_pw
            always_ff @(posedge i_clk) begin
                if (i_rst) begin
                    pw_words[g] <= 16'h0000;
                end else if (state == dpl_pkg::ST_XFER && i_data_wr &&
                             word_idx == 8'(g + dpl_pkg::PW_FIRST_WORD)) begin
                    pw_words[g] <= i_data;
                end
            end
            assign pw_rx[g*16 +: 16] = pw_words[g];
        end
    endgenerate

    // ------------------------------------------------------------
    // Decisions at execution
    // ------------------------------------------------------------
    assign is_master = ctrl_word[dpl_pkg::CTRL_ID_BIT];

    always_comb begin
        if (is_master) begin
            pw_match = (pw_rx == master_pw);
        end else begin
            pw_match = (pw_rx == user_pw);
        end
    end

    assign unlock_ok  = (state == dpl_pkg::ST_EXEC) && (cur_op == dpl_pkg::OP_UNLOCK) &&
                        !(is_master && o_level_max) && pw_match;
    assign unlock_bad = (state == dpl_pkg::ST_EXEC) && (cur_op == dpl_pkg::OP_UNLOCK) &&
                        !(is_master && o_level_max) && !pw_match;
    assign set_ok     = (state == dpl_pkg::ST_EXEC) && (cur_op == dpl_pkg::OP_SET_PASSWORD) &&
                        !(is_master && rev_word == dpl_pkg::REV_RESERVED);
    assign exec_abort = (state == dpl_pkg::ST_EXEC) && !unlock_ok && !set_ok;

    // ------------------------------------------------------------
    // Stored passwords and revision code
    // ------------------------------------------------------------
    // set-password stores password
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            user_pw   <= '0;
            master_pw <= '0;
        end else if (set_ok) begin
            if (is_master) begin
                master_pw <= pw_rx;
            end else begin
                user_pw <= pw_rx;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_ident_word92 <= dpl_pkg::REV_DEFAULT;
        end else if (set_ok && is_master) begin
            o_ident_word92 <= rev_word;
        end
    end

    // ------------------------------------------------------------
    // Lock feature, level and lock mode
    // ------------------------------------------------------------
    // level bit from user set
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_lock_enabled <= 1'b0;
            o_level_max    <= 1'b0;
        end else if (set_ok && !is_master) begin
            o_lock_enabled <= 1'b1;
            o_level_max    <= ctrl_word[dpl_pkg::CTRL_LEVEL_BIT];
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_locked <= 1'b0;
        end else if (i_hard_rst) begin
            o_locked <= o_lock_enabled;
        end else if (unlock_ok) begin
            o_locked <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || i_hard_rst) begin
            o_attempts <= ATTEMPTS_INIT;
        end else if (unlock_bad && o_attempts != 3'h0) begin
            o_attempts <= o_attempts - 3'h1;
        end
    end

    // ------------------------------------------------------------
    // Completion and flags
    // ------------------------------------------------------------
    // abort sets error bits
    always_ff @(posedge i_clk) begin
        if (i_rst || i_hard_rst) begin
            abort_flag <= 1'b0;
        end else if (early_abort || state == dpl_pkg::ST_EXEC) begin
            abort_flag <= early_abort || exec_abort;
        end else if (take_cmd) begin
            abort_flag <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst || i_hard_rst) begin
            o_cmd_done <= 1'b0;
        end else begin
            o_cmd_done <= early_abort || (state == dpl_pkg::ST_EXEC);
        end
    end

    always_comb begin
        o_status     = '0;
        o_status.bsy = (state == dpl_pkg::ST_EXEC);
        o_status.rdy = (state != dpl_pkg::ST_EXEC);
        o_status.dsc = 1'b1;
        o_status.drq = (state == dpl_pkg::ST_XFER);
        o_status.err = abort_flag;
        o_error      = '0;
        o_error.abt  = abort_flag;
    end

endmodule

// ---- src/dpl_pkg.sv ----
// Constants and carrier types for the password lock command block.
// Assumes one clock domain and 16-bit data register transfers from the host.
package dpl_pkg;

    // ------------------------------------------------------------
    // Command opcodes
    // ------------------------------------------------------------
    localparam logic [7:0]  OP_SET_PASSWORD = 8'hf1;
    localparam logic [7:0]  OP_UNLOCK       = 8'hf2;

    // ------------------------------------------------------------
    // Parameter sector layout
    // ------------------------------------------------------------
    localparam int          SECTOR_WORDS    = 256;
    localparam int          PW_FIRST_WORD   = 1;
    localparam int          PW_WORDS        = 16;
    localparam int          PW_BITS         = 256;
    localparam logic [7:0]  REV_WORD        = 8'h11;
    localparam int          CTRL_ID_BIT     = 0;
    localparam int          CTRL_LEVEL_BIT  = 8;

    // ------------------------------------------------------------
    // Revision code values and counter reset
    // ------------------------------------------------------------
    localparam logic [15:0] REV_DEFAULT     = 16'hfffe;
    localparam logic [15:0] REV_RESERVED    = 16'hffff;
    localparam int          ATTEMPTS_RESET  = 5;

    // ------------------------------------------------------------
    // Status and error flag layouts
    // ------------------------------------------------------------
    typedef struct packed {
        logic bsy;
        logic rdy;
        logic df;
        logic dsc;
        logic drq;
        logic cor;
        logic idx;
        logic err;
    } dpl_status_t;

    typedef struct packed {
        logic crc;
        logic unc;
        logic zero5;
        logic idn;
        logic zero3;
        logic abt;
        logic ton;
        logic amn;
    } dpl_error_t;

    // ------------------------------------------------------------
    // Command sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_XFER = 2'b01,
        ST_EXEC = 2'b11
    } dpl_state_t;

endpackage

// ---- tb/dpl_core_chk.sv ----
// Checker for the password lock command block.
// Assumes one clock domain; i_rst masks every property.
`timescale 1ns/10ps
module dpl_core_chk #(
    parameter int ATTEMPTS = 5
) (
    input wire logic                 i_clk,
    input wire logic                 i_rst,
    input wire logic                 i_hard_rst,
    input wire logic                 i_frozen,
    input wire logic                 i_cmd_wr,
    input wire logic [7:0]           i_cmd,
    input wire dpl_pkg::dpl_status_t o_status,
    input wire dpl_pkg::dpl_error_t  o_error,
    input wire logic                 o_cmd_done,
    input wire logic                 o_locked,
    input wire logic                 o_lock_enabled,
    input wire logic [2:0]           o_attempts,
    input wire logic [15:0]          o_ident_word92
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    sequence take_s;
        i_cmd_wr && o_status.rdy && !o_status.drq && (i_cmd == dpl_pkg::OP_SET_PASSWORD
            || i_cmd == dpl_pkg::OP_UNLOCK);
    endsequence
    sequence end_s;
        !o_status.bsy && o_status.rdy && o_cmd_done;
    endsequence
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    xfer_start_a: assert property (
        take_s ##0 (!i_frozen && o_attempts != 3'h0) |=> o_status.drq && !o_cmd_done)
        else $error("sector not requested");
    frozen_abort_a: assert property (
        take_s ##0 i_frozen |=> end_s ##0 o_error.abt && o_status.err)
        else $error("frozen command not aborted");
    spent_abort_a: assert property (
        take_s ##0 o_attempts == 3'h0 |=> end_s ##0 o_error.abt)
        else $error("spent counter command not aborted");
    busy_done_a: assert property (
        o_status.bsy |=> end_s) else $error("busy not followed by completion");
    hard_load_a: assert property (
        i_hard_rst |=> o_attempts == 3'(ATTEMPTS) && o_locked == $past(o_lock_enabled))
        else $error("hard reset load wrong");
    count_step_a: assert property (
        !$past(i_rst) && !$past(i_hard_rst) && o_attempts != $past(o_attempts)
        |-> o_attempts == $past(o_attempts) - 3'h1 && o_cmd_done && o_error.abt)
        else $error("attempt counter moved wrongly");
    lock_rise_a: assert property (
        $rose(o_locked) |-> $past(i_hard_rst)) else $error("locked without reset");
    unlock_done_a: assert property (
        !$past(i_rst) && $fell(o_locked) |-> o_cmd_done && !o_error.abt)
        else $error("unlock without good completion");
    rev_hold_a: assert property (
        !$past(i_rst) && o_ident_word92 != $past(o_ident_word92) |-> o_cmd_done && !o_error.abt)
        else $error("revision code changed wrongly");
endmodule
bind dpl_core dpl_core_chk #(.ATTEMPTS(ATTEMPTS)) dpl_core_chk_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_hard_rst(i_hard_rst), .i_frozen(i_frozen),
    .i_cmd_wr(i_cmd_wr), .i_cmd(i_cmd), .o_status(o_status), .o_error(o_error),
    .o_cmd_done(o_cmd_done), .o_locked(o_locked), .o_lock_enabled(o_lock_enabled),
    .o_attempts(o_attempts), .o_ident_word92(o_ident_word92));

// ---- tb/dpl_host.sv ----
// Host model: issues a command and moves one parameter sector.
// Assumes the block samples its inputs at the rising edge of i_clk.
`timescale 1ns/10ps
module dpl_host (
    input  wire logic                 i_clk,
    input  wire dpl_pkg::dpl_status_t i_status,
    input  wire logic                 i_done,
    output logic                      o_cmd_wr,
    output logic [7:0]                o_cmd,
    output logic                      o_data_wr,
    output logic [15:0]               o_data
);
    initial begin
        o_cmd_wr = 1'b0;
        o_cmd = 8'h00;
        o_data_wr = 1'b0;
        o_data = 16'h0000;
    end
    task automatic xfer(input logic [7:0] op, input logic [15:0] ctl, input logic [255:0] pw,
                        input logic [15:0] rev, input int gap, output bit to,
                        output bit sent);
        logic [15:0] w;
        int          n;
        @(posedge i_clk);
        o_cmd_wr <= 1'b1;
        o_cmd    <= op;
        @(posedge i_clk);
        o_cmd_wr <= 1'b0;
        for (n = 0; n < 4 && !i_status.drq && !i_done; n++) @(negedge i_clk);
        // sector sent only after a data request
        sent = i_status.drq;
        if (i_status.drq) begin
            for (n = 0; n < 256; n++) begin
                w = n == 0 ? ctl : n < 17 ? pw[16*(n-1) +: 16] : n == 17 ? rev : 16'(~n);
                @(posedge i_clk);
                o_data_wr <= 1'b1;
                o_data    <= w;
                if (gap > 0 && n < 255) begin
                    @(posedge i_clk);
                    o_data_wr <= 1'b0;
                    o_data    <= ~w;
                    repeat (gap - 1) @(posedge i_clk);
                end
            end
            @(posedge i_clk);
            o_data_wr <= 1'b0;
        end
        to = 1'b1;
        for (n = 0; n < 8 && to; n++) begin
            if (i_done) to = 1'b0;
            else @(negedge i_clk);
        end
    endtask
endmodule

// ---- tb/drive_password_lock_commands_tb.sv ----
// Self-checking bench for the password lock command block.
// Assumes the host model and the bound checker.
`timescale 1ns/10ps
module drive_password_lock_commands_tb;
    localparam logic [7:0] SETP = dpl_pkg::OP_SET_PASSWORD;
    localparam logic [7:0] UNLK = dpl_pkg::OP_UNLOCK;
    logic                clk = 1'b0, rst = 1'b1, hrst = 1'b0, frz = 1'b0;
    logic                cmd_wr, data_wr, done, locked, lock_en, lvl;
    logic [7:0]          cmd_op;
    logic [15:0]         data, word92;
    logic [2:0]          att_o;
    dpl_pkg::dpl_status_t st;
    dpl_pkg::dpl_error_t err;
    logic [255:0]        mpw = '0, upw = '0, ua, mb;
    logic [15:0]         e_rev = 16'hfffe;
    bit                  e_lock, e_len, e_lvl, e_abt;
    int                  att = 5, fail_count = 0, n_tests = 0;
    always #20 clk = ~clk;
    dpl_host host_i (.i_clk(clk), .i_status(st), .i_done(done), .o_cmd_wr(cmd_wr),
        .o_cmd(cmd_op), .o_data_wr(data_wr), .o_data(data));
    dpl_core dpl_core_i (.i_clk(clk), .i_rst(rst), .i_hard_rst(hrst), .i_frozen(frz),
        .i_cmd_wr(cmd_wr), .i_cmd(cmd_op), .i_data_wr(data_wr), .i_data(data),
        .o_status(st), .o_error(err), .o_cmd_done(done), .o_locked(locked),
        .o_lock_enabled(lock_en), .o_level_max(lvl), .o_attempts(att_o),
        .o_ident_word92(word92));
    // ------------------------------------------------------------
    // Helpers and reference model
    // ------------------------------------------------------------
    task automatic give_verdict();
        if (fail_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    function automatic logic [255:0] rnd();
        logic [255:0] r;
        for (int i = 0; i < 8; i++) r[32*i +: 32] = $urandom;
        return r;
    endfunction
    task automatic hard();
        @(posedge clk);
        hrst <= 1'b1;
        @(posedge clk);
        hrst <= 1'b0;
        e_lock = e_len;
        att = 5;
        @(negedge clk);
        chk("locked", 16'(locked), 16'(e_lock));
        chk("attempts", 16'(att_o), 16'(att));
    endtask
    task automatic cmd(input logic [7:0] op, input logic [15:0] ctl, input logic [255:0] pw,
                       input logic [15:0] rev);
        bit to;
        bit sent;
        host_i.xfer(op, ctl, pw, rev, $urandom % 3, to, sent);
        if (to) begin
            fail_count++;
            give_verdict();
        end
        e_abt = frz || att == 0;
        chk("sector_sent", 16'(sent), 16'(!e_abt));
        if (!e_abt && op == SETP) begin
            if (ctl[0] && rev == 16'hffff) e_abt = 1'b1;
            else if (ctl[0]) begin
                mpw = pw;
                e_rev = rev;
            end else begin
                upw = pw;
                e_len = 1'b1;
                e_lvl = ctl[8];
            end
        end else if (!e_abt) begin
            if (ctl[0] && e_lvl) e_abt = 1'b1;
            else if (pw !== (ctl[0] ? mpw : upw)) begin
                e_abt = 1'b1;
                att--;
            end else e_lock = 1'b0;
        end
        chk("abort", 16'(err.abt), 16'(e_abt));
        chk("err", 16'(st.err), 16'(e_abt));
        chk("status", 16'(st), 16'h0050 | 16'(e_abt));
        chk("error", 16'(err), 16'(e_abt) << 2);
        chk("locked", 16'(locked), 16'(e_lock));
        chk("lock_en", 16'(lock_en), 16'(e_len));
        chk("level", 16'(lvl), 16'(e_lvl));
        chk("attempts", 16'(att_o), 16'(att));
        chk("word92", word92, e_rev);
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(85));
        ua = rnd();
        mb = rnd();
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        cmd(SETP, 16'h0001, mb, 16'h1234);
        cmd(SETP, 16'h0000, ua, 16'h5555);
        hard();
        cmd(UNLK, 16'h0000, ua ^ (256'h1 << 255), 16'h0000);
        cmd(UNLK, 16'h0001, mb, 16'h0000);
        hard();
        cmd(SETP, 16'h0100, ua, 16'h0000);
        cmd(SETP, 16'h0001, mb, 16'hffff);
        hard();
        cmd(UNLK, 16'h0001, mb, 16'h0000);
        repeat (5) cmd(UNLK, 16'h0000, mb, 16'h0000);
        cmd(UNLK, 16'h0000, ua, 16'h0000);
        hard();
        @(posedge clk) frz <= 1'b1;
        cmd(SETP, 16'h0001, mb, 16'h0042);
        @(posedge clk) frz <= 1'b0;
        cmd(UNLK, 16'h0000, ua, 16'h0000);
        give_verdict();
    end
endmodule
